// File: src/btc_defs.svh
/*
 * Constants of the boundary-scan test logic: instruction codes, chain
 * lengths, cell kinds and reset values.
 * Assumes inclusion by the scan-cell and the top-level design files.
 */
`ifndef BTC_DEFS_SVH
`define BTC_DEFS_SVH

// How it works
// - Every pin owns a three-bit cell, each bit with capture; only user-pin cells add update.
// - Capture takes core value, core enable, pad; update drives pad and core.
// - Cell controls come from the TAP; cell mode decodes the instruction.
// - Cells chain serially into one register from TDI to TDO.
// - Dedicated input cells capture 0, 1 and the pad; no update drive.
// - Dedicated bidirectional cells capture core and pad; update drives nothing.
// - Test pins, supply and ground have no cell in the chain.
// - The instruction register is ten bits and decodes seven instructions.
// - A sixteen-state TAP advances on rising TCK under TMS.
// - Test-Logic-Reset leaves pins normal and loads IDCODE.
// - Power-up reset puts the TAP in Test-Logic-Reset.
// - Five TCK edges with TMS high reach and hold Test-Logic-Reset.
// - TDO drives only in shift states, switching on falling TCK.
// - Shift-IR sends the captured pattern 10'h001 out on falling TCK.
// - Instruction bits enter on rising TCK; last bit with TMS high.
// - Sample captures the live core and pad signals.
// - Sample leaves pads and core fed by live signals.
// - Shift-DR moves capture bits toward TDO while TDI refills them.
// - Update-DR copies every user-pin capture bit into its update bit.
// - TMS high twice from Shift-DR reaches Update-DR via Exit1-DR.
// - Extest drives pad value and enable from the update bits.
// - An update enable bit of one tri-states the pad driver.
// - All-ones selects bypass: one bit in on rise, out on fall.

`define BTC_IR_LEN       10
`define BTC_ID_LEN       32
`define BTC_OP_EXTEST    10'h000
`define BTC_OP_SAMPLE    10'h005
`define BTC_OP_IDCODE    10'h006
`define BTC_OP_USERCODE  10'h007
`define BTC_OP_CLAMP     10'h00a
`define BTC_OP_HIGHZ     10'h00b
`define BTC_OP_BYPASS    10'h3ff
`define BTC_IR_CAPTURE   10'h001
`define BTC_KIND_USER    0
`define BTC_KIND_DIN     1
`define BTC_KIND_DBI     2
`define BTC_CELL_RESET   3'b010

`endif

// File: src/btc_pkg.sv
/*
 * Types shared by the boundary-scan top level and its cells.
 * Assumes nothing of its surroundings.
 */
package btc_pkg;

    typedef enum logic [3:0] {
        ST_TLR      = 4'hf,
        ST_RTI      = 4'hc,
        ST_SEL_DR   = 4'h7,
        ST_CAP_DR   = 4'h6,
        ST_SHIFT_DR = 4'h2,
        ST_EXIT1_DR = 4'h1,
        ST_PAUSE_DR = 4'h3,
        ST_EXIT2_DR = 4'h0,
        ST_UPD_DR   = 4'h5,
        ST_SEL_IR   = 4'h4,
        ST_CAP_IR   = 4'he,
        ST_SHIFT_IR = 4'ha,
        ST_EXIT1_IR = 4'h9,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h8,
        ST_UPD_IR   = 4'hd
    } btc_tap_state_type;

    typedef enum logic [2:0] {
        MODE_SAMPLE   = 3'h0,
        MODE_EXTEST   = 3'h1,
        MODE_BYPASS   = 3'h2,
        MODE_IDCODE   = 3'h3,
        MODE_USERCODE = 3'h4,
        MODE_CLAMP    = 3'h5,
        MODE_HIGHZ    = 3'h6
    } btc_mode_type;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
    } btc_cell_ctl_type;

    // Enable bit is active low: one means the pad floats
    typedef struct packed {
        logic value;
        logic oe_n;
        logic drive;
    } btc_cell_bits_type;

endpackage

// File: src/btc_scan_cell.sv
/*
 * One three-bit boundary cell: capture stages that form part of the
 * serial chain, and update stages for user-pin cells only.
 * Assumes controls from the TAP, all on the rising TCK edge.
 */
`timescale 1ns/10ps
`default_nettype none
`include "btc_defs.svh"

module btc_scan_cell
    import btc_pkg::*;
#(
    parameter int KIND = `BTC_KIND_USER
) (
    input  wire logic              tck,
    input  wire logic              tap_rst,
    input  wire btc_cell_ctl_type  ctl,
    input  wire btc_cell_bits_type live,
    input  wire logic              cell_serial_in,
    output logic                   cell_serial_out,
    output btc_cell_bits_type      upd
);

    btc_cell_bits_type cap_q;
    btc_cell_bits_type src;

    always_comb begin
        src = live;
        if (KIND == `BTC_KIND_DIN) begin
            src.value = 1'b0;
            src.oe_n  = 1'b1;
        end
    end

    // Shift order: drive, then enable, then value toward the far end
    always_ff @(posedge tck) begin
        if (tap_rst)
            cap_q <= `BTC_CELL_RESET;
        else if (ctl.capture)
            cap_q <= src;
        else if (ctl.shift)
            cap_q <= {cap_q.oe_n, cap_q.drive, cell_serial_in};
    end

    assign cell_serial_out = cap_q.value;

    if (KIND == `BTC_KIND_USER) begin : g_upd
        btc_cell_bits_type upd_q;
        always_ff @(posedge tck) begin
            if (tap_rst)
                upd_q <= `BTC_CELL_RESET;
            else if (ctl.update)
                upd_q <= cap_q;
        end
        assign upd = upd_q;
        chk_cell_update : assert property (
            @(posedge tck) disable iff (tap_rst)
            ctl.update |=> upd == $past(cap_q))
            else $error("update stage did not take capture bits");
    end else begin : g_nc
        // Dedicated pins have no update stage; upd is tied to the cell reset value
        assign upd = `BTC_CELL_RESET;
    end

    chk_cell_capture : assert property (
        @(posedge tck) disable iff (tap_rst)
        ctl.capture |=> cap_q == $past(src))
        else $error("capture stage missed live signals");

endmodule // btc_scan_cell
`default_nettype wire

// File: src/btc_tap_top.sv
/*
 * Boundary-scan test logic: TAP controller, instruction register,
 * bypass and identification registers, and the chain of pin cells.
 * Assumes a tester on TCK/TMS/TDI/TDO and core logic on ref_clk.
 * Supply, ground and test pins carry no cell.
 */
`timescale 1ns/10ps
`default_nettype none
`include "btc_defs.svh"

module btc_tap_top
    import btc_pkg::*;
#(
    parameter int          N_USER    = 4,
    parameter int          N_DIN     = 2,
    parameter int          N_DBI     = 1,
    // Arbitrary identity values
    parameter logic [31:0] ID_CODE   = 32'h0000_1001,
    parameter logic [31:0] USER_CODE = 32'hffff_ffff,
    localparam int         N_PIN     = N_USER + N_DIN + N_DBI
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    input  wire logic [N_PIN-1:0] pad_in,
    output logic      [N_PIN-1:0] pad_out,
    output logic      [N_PIN-1:0] pad_oe,
    input  wire logic [N_PIN-1:0] core_output_value,
    input  wire logic [N_PIN-1:0] core_output_enable_n,
    output logic      [N_PIN-1:0] core_input_drive
);

    btc_tap_state_type        state_q;
    btc_tap_state_type        state_d;
    btc_mode_type             mode;
    btc_cell_ctl_type         cell_ctl;
    btc_cell_bits_type        live_w [N_PIN];
    btc_cell_bits_type        upd_w  [N_PIN];
    btc_cell_bits_type        hold_q [N_PIN];
    logic                     rst_s1_q;
    logic                     tap_rst_q;
    logic [`BTC_IR_LEN-1:0]   ir_sr_q;
    logic [`BTC_IR_LEN-1:0]   ir_q;
    logic [`BTC_ID_LEN-1:0]   id_q;
    logic                     byp_q;
    logic                     tdo_q;
    logic                     tdo_oe_q;
    logic                     dr_out;
    logic                     shift_ir;
    logic                     shift_dr;
    logic                     bsr_sel;
    logic [N_PIN:0]           chain;
    logic [N_PIN-1:0]         cval_s1_q;
    logic [N_PIN-1:0]         cval_s2_q;
    logic [N_PIN-1:0]         coen_s1_q;
    logic [N_PIN-1:0]         coen_s2_q;
    logic [N_PIN-1:0]         tpin_s1_q;
    logic [N_PIN-1:0]         tpin_s2_q;
    logic                     upd_tgl_q;
    logic [2:0]               flag_q;
    logic [2:0]               tgl_sync_q;
    logic [N_PIN-1:0]         rpin_s1_q;
    logic [N_PIN-1:0]         rpin_s2_q;
    logic [N_PIN-1:0]         pad_out_q;
    logic [N_PIN-1:0]         pad_oe_q;
    logic [N_PIN-1:0]         core_in_q;
    logic                     use_upd;
    logic                     ext_r;
    logic                     hiz_r;

    // Power-up reset reaches the TCK domain through two flops
    always_ff @(posedge tck) begin
        rst_s1_q  <= rst;
        tap_rst_q <= rst_s1_q;
    end

    // TAP state graph
    always_comb begin
        unique case (state_q)
            ST_TLR:      state_d = tms ? ST_TLR      : ST_RTI;
            ST_RTI:      state_d = tms ? ST_SEL_DR   : ST_RTI;
            ST_SEL_DR:   state_d = tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_d = tms ? ST_SEL_DR   : ST_RTI;
            ST_SEL_IR:   state_d = tms ? ST_TLR      : ST_CAP_IR;
            ST_CAP_IR:   state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_d = tms ? ST_SEL_DR   : ST_RTI;
        endcase
    end

    always_ff @(posedge tck) begin
        if (tap_rst_q)
            state_q <= ST_TLR;
        else
            state_q <= state_d;
    end

    assign shift_ir = (state_q == ST_SHIFT_IR);
    assign shift_dr = (state_q == ST_SHIFT_DR);

    // Instruction shift stage and held instruction
    always_ff @(posedge tck) begin
        if (tap_rst_q)
            ir_sr_q <= `BTC_IR_CAPTURE;
        else if (state_q == ST_CAP_IR)
            ir_sr_q <= `BTC_IR_CAPTURE;
        else if (shift_ir)
            ir_sr_q <= {tdi, ir_sr_q[`BTC_IR_LEN-1:1]};
    end

    always_ff @(posedge tck) begin
        if (tap_rst_q || state_q == ST_TLR)
            ir_q <= `BTC_OP_IDCODE;
        else if (state_q == ST_UPD_IR)
            ir_q <= ir_sr_q;
    end

    // Unknown codes fall back to bypass, as the standard expects
    always_comb begin
        unique case (ir_q)
            `BTC_OP_SAMPLE:   mode = MODE_SAMPLE;
            `BTC_OP_EXTEST:   mode = MODE_EXTEST;
            `BTC_OP_IDCODE:   mode = MODE_IDCODE;
            `BTC_OP_USERCODE: mode = MODE_USERCODE;
            `BTC_OP_CLAMP:    mode = MODE_CLAMP;
            `BTC_OP_HIGHZ:    mode = MODE_HIGHZ;
            `BTC_OP_BYPASS:   mode = MODE_BYPASS;
            default:          mode = MODE_BYPASS;
        endcase
    end

    assign bsr_sel = (mode == MODE_SAMPLE) || (mode == MODE_EXTEST);

    always_comb begin
        cell_ctl.capture = bsr_sel && (state_q == ST_CAP_DR);
        cell_ctl.shift   = bsr_sel && shift_dr;
        cell_ctl.update  = bsr_sel && (state_q == ST_UPD_DR);
    end

    // Bypass and identification data registers
    always_ff @(posedge tck) begin
        if (tap_rst_q)
            byp_q <= 1'b0;
        else if (state_q == ST_CAP_DR)
            byp_q <= 1'b0;
        else if (shift_dr)
            byp_q <= tdi;
    end

    always_ff @(posedge tck) begin
        if (tap_rst_q)
            id_q <= ID_CODE;
        else if (state_q == ST_CAP_DR)
            id_q <= (mode == MODE_USERCODE) ? USER_CODE : ID_CODE;
        else if (shift_dr)
            id_q <= {tdi, id_q[`BTC_ID_LEN-1:1]};
    end

    // Core and pad levels enter the TCK domain through two flops
    always_ff @(posedge tck) begin
        cval_s1_q <= core_output_value;
        cval_s2_q <= cval_s1_q;
        coen_s1_q <= core_output_enable_n;
        coen_s2_q <= coen_s1_q;
        tpin_s1_q <= pad_in;
        tpin_s2_q <= tpin_s1_q;
    end

    assign chain[0] = tdi;

    for (genvar i = 0; i < N_PIN; i++) begin : g_cell
        localparam int KIND = (i < N_USER) ? `BTC_KIND_USER :
                              (i < N_USER + N_DIN) ? `BTC_KIND_DIN :
                              `BTC_KIND_DBI;
        assign live_w[i] = '{value: cval_s2_q[i],
                             oe_n:  coen_s2_q[i],
                             drive: tpin_s2_q[i]};
        btc_scan_cell #(
            .KIND(KIND)
        ) u_cell (
            .tck            (tck),
            .tap_rst        (tap_rst_q),
            .ctl            (cell_ctl),
            .live           (live_w[i]),
            .cell_serial_in (chain[i]),
            .cell_serial_out(chain[i+1]),
            .upd            (upd_w[i])
        );
    end

    always_comb begin
        unique case (mode)
            MODE_SAMPLE, MODE_EXTEST:    dr_out = chain[N_PIN];
            MODE_IDCODE, MODE_USERCODE:  dr_out = id_q[0];
            MODE_BYPASS, MODE_CLAMP,
            MODE_HIGHZ:                  dr_out = byp_q;
            default:                     dr_out = byp_q;
        endcase
    end

    // TDO changes on the falling edge, half a period clear of the sampler
    always_ff @(negedge tck) begin
        if (tap_rst_q) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_oe_q <= shift_ir || shift_dr;
            tdo_q    <= shift_ir ? ir_sr_q[0] : dr_out;
        end
    end

    assign tdo    = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // Each Update-DR in sample or extest and each instruction load flips this toggle for the
    // core clock to follow; the mode flags then cross as one word
    always_ff @(posedge tck) begin
        if (tap_rst_q)
            upd_tgl_q <= 1'b0;
        else if (cell_ctl.update || state_q == ST_UPD_IR ||
                 (state_q == ST_TLR && ir_q != `BTC_OP_IDCODE))
            upd_tgl_q <= ~upd_tgl_q;
    end

    // Core-clock side: update toggle and pad levels
    always_ff @(posedge ref_clk) begin
        tgl_sync_q <= {tgl_sync_q[1:0], upd_tgl_q};
        rpin_s1_q  <= pad_in;
        rpin_s2_q  <= rpin_s1_q;
    end

    assign ext_r   = flag_q[2];
    assign hiz_r   = flag_q[0];
    assign use_upd = flag_q[2] || flag_q[1];

    // Update bits and instruction stand for several TCK periods after the
    // toggle, so a bulk copy on the synchronised edge cannot catch them
    // mid-change; this needs TCK no faster than the core clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_q <= 3'h0;
            for (int i = 0; i < N_PIN; i++)
                hold_q[i] <= `BTC_CELL_RESET;
        end else if (tgl_sync_q[2] ^ tgl_sync_q[1]) begin
            flag_q <= {mode == MODE_EXTEST, mode == MODE_CLAMP,
                       mode == MODE_HIGHZ};
            for (int i = 0; i < N_PIN; i++)
                hold_q[i] <= upd_w[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pad_out_q <= '0;
            pad_oe_q  <= '0;
            core_in_q <= '0;
        end else begin
            for (int i = 0; i < N_PIN; i++) begin
                if (i < N_USER && use_upd) begin
                    pad_out_q[i] <= hold_q[i].value;
                    pad_oe_q[i]  <= ~hold_q[i].oe_n;
                end else if (i < N_USER && hiz_r) begin
                    pad_out_q[i] <= core_output_value[i];
                    pad_oe_q[i]  <= 1'b0;
                end else if (i < N_USER || i >= N_USER + N_DIN) begin
                    pad_out_q[i] <= core_output_value[i];
                    pad_oe_q[i]  <= ~core_output_enable_n[i];
                end else begin
                    pad_out_q[i] <= 1'b0;
                    pad_oe_q[i]  <= 1'b0;
                end
                if (i < N_USER && ext_r)
                    core_in_q[i] <= hold_q[i].drive;
                else
                    core_in_q[i] <= rpin_s2_q[i];
            end
        end
    end

    assign pad_out          = pad_out_q;
    assign pad_oe           = pad_oe_q;
    assign core_input_drive = core_in_q;

    sequence s_tms_high5;
        tms [*5];
    endsequence

    sequence s_reset_to_shift_ir;
        (state_q == ST_TLR && !tms) ##1 tms ##1 tms ##1 !tms ##1 !tms;
    endsequence

    sequence s_exit_to_update;
        (shift_dr && tms) ##1 tms;
    endsequence

    chk_five_tms_reset : assert property (@(posedge tck)
        disable iff (tap_rst_q) s_tms_high5 |=> state_q == ST_TLR)
        else $error("five TMS highs did not reach reset");

    chk_tlr_hold : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        (state_q == ST_TLR && tms) |=> state_q == ST_TLR)
        else $error("left reset state with TMS high");

    chk_walk_shift_ir : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        s_reset_to_shift_ir |=> state_q == ST_SHIFT_IR)
        else $error("01100 from reset did not reach Shift-IR");

    chk_walk_update_dr : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        s_exit_to_update |=> state_q == ST_UPD_DR)
        else $error("two TMS highs from Shift-DR missed Update-DR");

    chk_ir_load : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        state_q == ST_UPD_IR |=> ir_q == $past(ir_sr_q))
        else $error("instruction not loaded at Update-IR");

    chk_tlr_idcode : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        state_q == ST_TLR |=> ir_q == `BTC_OP_IDCODE)
        else $error("reset state did not select IDCODE");

    chk_tdo_drive : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        $past(tap_rst_q) == 1'b0 |-> tdo_oe == (shift_ir || shift_dr))
        else $error("TDO enable out of step with shift state");

    chk_bypass_path : assert property (@(posedge tck)
        disable iff (tap_rst_q)
        (shift_dr && mode == MODE_BYPASS) |=> byp_q == $past(tdi))
        else $error("bypass stage did not take TDI");

    chk_extest_oe : assert property (@(posedge ref_clk)
        disable iff (rst)
        (flag_q[2] && !$rose(flag_q[2]))
        |=> pad_oe_q[0] == ~$past(hold_q[0].oe_n))
        else $error("extest enable not taken from update bit");

endmodule // btc_tap_top
`default_nettype wire

// File: test/btc_tester.sv
/*
 * Behavioural scan tester: makes tck, drives tms and tdi, reads tdo.
 * Assumes the bench calls its tasks one at a time; tck idles low.
 */
`timescale 1ns/10ps
`default_nettype none

module btc_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One tck period from fall to fall; tms and tdi change with the fall,
    // tdo is read just before the rising edge
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #16;
        o = tdo_oe ? tdo : 1'bz;
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask

    // Idle tdi sits high, as its pull-up would leave it
    task automatic run(input int n, input logic m);
        logic o;
        for (int k = 0; k < n; k++) step(m, 1'b1, o);
    endtask

    task automatic reset_tap();
        run(5, 1'b1);
        run(1, 1'b0);
    endtask

    // From Run-Test/Idle through a shift of n bits, lsb first, back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = '0;
        run(1, 1'b1);
        if (ir) run(1, 1'b1);
        run(2, 1'b0);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], o);
            dout[k] = o;
        end
        run(1, 1'b1);
        run(1, 1'b0);
    endtask
endmodule // btc_tester

`default_nettype wire

// File: test/btc_tap_top_tb.sv
/*
 * Self-checking bench of the boundary-scan logic with a scan tester.
 * Assumes default pin counts: four user, two input, one bidirectional.
 */
`timescale 1ns/10ps
`default_nettype none
`include "btc_defs.svh"

module btc_tap_top_tb;
    localparam logic [31:0] ID = 32'h0000_1001; // Arbitrary value
    localparam logic [31:0] UC = 32'h0000_2002; // Arbitrary value
    localparam logic [20:0] PRE1 = 21'h1a_5c36;
    localparam logic [20:0] PRE2 = 21'h05_a3c9;
    logic ref_clk, rst, tck, tms, tdi, tdo, tdo_oe;
    logic [6:0] pad_in, pad_out, pad_oe, cov, coen_n, cid;
    logic [63:0] d;
    int n_errors = 0;
    int checks_done = 0;

    btc_tap_top #(.ID_CODE(ID), .USER_CODE(UC)) i_btc_tap_top (
        .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .core_output_value(cov),
        .core_output_enable_n(coen_n), .core_input_drive(cid));
    btc_tester tester (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Expected pads; shift-order index 3*(6-p): value, oe_n, drive
    function automatic logic [20:0] pads(input logic ext,
                                         input logic [20:0] pre);
        logic [6:0] po, pe, ci;
        int b;
        po = cov;
        pe = ~coen_n;
        ci = pad_in;
        for (int p = 0; p < 7; p++) begin
            b = 3 * (6 - p);
            if (p == 4 || p == 5) begin
                po[p] = 1'b0;
                pe[p] = 1'b0;
            end
            if (ext && p < 4) begin
                po[p] = pre[b];
                pe[p] = ~pre[b + 1];
                ci[p] = pre[b + 2];
            end
        end
        return {po, pe, ci};
    endfunction

    function automatic logic [20:0] capt();
        logic [20:0] c;
        int b;
        for (int p = 0; p < 7; p++) begin
            b = 3 * (6 - p);
            c[b] = (p == 4 || p == 5) ? 1'b0 : cov[p];
            c[b + 1] = (p == 4 || p == 5) ? 1'b1 : coen_n[p];
            c[b + 2] = pad_in[p];
        end
        return c;
    endfunction

    task automatic seen_pads(input logic ext, input logic [20:0] pre);
        repeat (10) @(negedge ref_clk);
        check({pad_out, pad_oe, cid}, pads(ext, pre));
    endtask

    task automatic t_reset();
        @(negedge ref_clk);
        check(tdo_oe, 1'b0);
        seen_pads(1'b0, '0);
        $display("test reset done");
    endtask

    task automatic t_sample();
        tester.scan(1'b1, 10, `BTC_OP_SAMPLE, d);
        check(d[9:0], `BTC_IR_CAPTURE);
        @(negedge ref_clk);
        check(tdo_oe, 1'b0);
        tester.scan(1'b0, 21, PRE1, d);
        check(d[20:0], capt());
        seen_pads(1'b0, '0);
        $display("test sample done");
    endtask

    task automatic t_extest();
        tester.scan(1'b1, 10, `BTC_OP_EXTEST, d);
        seen_pads(1'b1, PRE1);
        tester.scan(1'b0, 21, PRE2, d);
        seen_pads(1'b1, PRE2);
        $display("test extest done");
    endtask

    task automatic t_bypass();
        tester.scan(1'b1, 10, `BTC_OP_BYPASS, d);
        tester.scan(1'b0, 8, 64'hb4, d);
        check(d[7:1], 7'h34);
        $display("test bypass done");
    endtask

    task automatic t_tlr();
        tester.scan(1'b1, 10, `BTC_OP_EXTEST, d);
        tester.run(8, 1'b1);
        seen_pads(1'b0, '0);
        tester.run(1, 1'b0);
        tester.scan(1'b0, 32, '0, d);
        check(d[31:0], ID);
        $display("test logic reset done");
    endtask

    // Clamp and high-impedance pads, then the user code register
    task automatic t_modes();
        logic [20:0] e;
        tester.scan(1'b1, 10, `BTC_OP_CLAMP, d);
        e = pads(1'b1, PRE2);
        e[6:0] = pad_in;
        repeat (10) @(negedge ref_clk);
        check({pad_out, pad_oe, cid}, e);
        tester.scan(1'b1, 10, `BTC_OP_HIGHZ, d);
        e = pads(1'b0, '0);
        e[10:7] = 4'h0;
        repeat (10) @(negedge ref_clk);
        check({pad_out, pad_oe, cid}, e);
        tester.scan(1'b1, 10, `BTC_OP_USERCODE, d);
        tester.scan(1'b0, 32, '0, d);
        check(d[31:0], UC);
        $display("test modes done");
    endtask

    initial begin
        rst = 1'b1;
        pad_in = 7'h33;
        cov = 7'h5a;
        coen_n = 7'h0c;
        fork
            tester.run(6, 1'b1);
            repeat (16) @(negedge ref_clk);
        join
        @(negedge ref_clk);
        rst = 1'b0;
        tester.run(3, 1'b1);
        tester.run(1, 1'b0);
        t_reset();
        t_sample();
        t_extest();
        t_bypass();
        t_tlr();
        t_modes();
        conclude();
    end

    // The tests take about 9 us; a hang stops at over thirty times that
    initial begin
        #300_000;
        n_errors++;
        conclude();
    end
endmodule // btc_tap_top_tb

`default_nettype wire
